// [rtcm_pkg.sv]
// Register map constants for the real-time clock register bank
package rtcm_pkg;
	localparam int          ADDR_W      = 6;
	localparam int          NREG        = 55;
	localparam logic [5:0]  ADDR_FIRST  = 6'h00;
	localparam logic [5:0]  ADDR_LAST   = 6'h36;
	localparam logic [5:0]  A_GEN_CTL   = 6'h00;
	localparam logic [5:0]  A_FLAG_CTL  = 6'h01;
	localparam logic [5:0]  A_CAP_FLAGS = 6'h03;
	localparam logic [5:0]  A_SOFT_RST  = 6'h05;
	localparam logic [5:0]  A_HUND      = 6'h06;
	localparam logic [5:0]  A_SEC       = 6'h07;
	localparam logic [5:0]  A_MIN       = 6'h08;
	localparam logic [5:0]  A_HOUR      = 6'h09;
	localparam logic [5:0]  A_DAY       = 6'h0A;
	localparam logic [5:0]  A_WDAY      = 6'h0B;
	localparam logic [5:0]  A_MON       = 6'h0C;
	localparam logic [5:0]  A_YEAR      = 6'h0D;
	localparam logic [5:0]  A_AL_SEC    = 6'h0E;
	localparam logic [5:0]  A_AL_MIN    = 6'h0F;
	localparam logic [5:0]  A_AL_HOUR   = 6'h10;
	localparam logic [5:0]  A_AL_DAY    = 6'h11;
	localparam logic [5:0]  A_AL_WDAY   = 6'h12;
	localparam logic [5:0]  A_DIVIDED_CLOCK_PIN    = 6'h13;
	localparam logic [5:0]  A_TS_BASE   = 6'h14;
	localparam logic [5:0]  A_TS_END    = 6'h2F;
	localparam int          TS_STRIDE   = 7;
	localparam int          TS_CHANS    = 4;
	localparam logic [5:0]  A_WD_CTL    = 6'h35;
	localparam logic [5:0]  A_WD_VAL    = 6'h36;
	// Bit positions
	localparam int          B_STOP      = 5;
	localparam int          B_12_24     = 2;
	localparam int          B_WATCHDOG_EXPIRED_FLAG      = 6;
	localparam int          B_AF        = 4;
	localparam int          B_AIE       = 1;
	localparam int          B_CPR       = 7;
	localparam int          B_SR        = 3;
	localparam int          B_CTS       = 0;
	localparam int          B_OTPR      = 5;
	localparam int          B_AE        = 7;
	localparam int          B_WD_EN     = 7;
	localparam int          B_TSF1      = 7;
	// Clock out, temperature interval and pending tick limit
	localparam logic [2:0]  COF_OFF     = 3'h7;
	localparam logic [2:0]  COF_1HZ     = 3'h6;
	localparam int          SHIFT_1HZ   = 15;
	localparam logic [5:0]  TEMP_MAX_MIN = 6'h20;
	localparam logic [7:0]  PEND_MAX    = 8'hFF;

	function automatic logic [7:0] reset_value(input logic [5:0] a);
		case (a)
			6'h00: reset_value = 8'h08;
			6'h02: reset_value = 8'hE0;
			6'h05: reset_value = 8'h24;
			6'h07: reset_value = 8'h80;
			6'h0A, 6'h0B, 6'h0C, 6'h0D: reset_value = 8'h01;
			6'h0E, 6'h0F, 6'h10, 6'h11, 6'h12: reset_value = 8'h80;
			default: reset_value = 8'h00;
		endcase
	endfunction

	// Readable bits; everything else reads zero
	function automatic logic [7:0] read_mask(input logic [5:0] a);
		case (a)
			6'h01: read_mask = 8'hD2;
			6'h03, 6'h04: read_mask = 8'hF0;
			6'h05: read_mask = 8'h89;
			6'h08: read_mask = 8'h7F;
			6'h09, 6'h0A: read_mask = 8'h3F;
			6'h0B: read_mask = 8'h07;
			6'h0C: read_mask = 8'h1F;
			6'h10, 6'h11: read_mask = 8'hBF;
			6'h12: read_mask = 8'h87;
			6'h13: read_mask = 8'hE7;
			6'h14, 6'h1B, 6'h22, 6'h29: read_mask = 8'hDF;
			6'h15, 6'h16, 6'h1C, 6'h1D, 6'h23, 6'h24, 6'h2A, 6'h2B: read_mask = 8'h7F;
			6'h17, 6'h18, 6'h1E, 6'h1F, 6'h25, 6'h26, 6'h2C, 6'h2D: read_mask = 8'h3F;
			6'h19, 6'h20, 6'h27, 6'h2E: read_mask = 8'h1F;
			default: read_mask = (a > ADDR_LAST) ? 8'h00 : 8'hFF;
		endcase
	endfunction
endpackage

// [rtcm_register_map.sv]
// Register bank, calendar counters, alarm, capture, watchdog and clock out
// How it works
// - Pointer steps by one after each data byte read or written.
// - Pointer past the last register wraps back to the first.
// - Day rollover follows month length and leap years.
// - Hours run in twelve-hour with half-day bit, or twenty-four-hour.
// - Time and date counters hold packed BCD; other registers binary.
// - Time counters frozen while a bus transaction runs.
// - Capture updates wait until the transaction has finished.
// - Unused bits always read zero.
// - Undefined bit keeps its value across every reset.
// - Temperature interval programmable, 32 minutes default down to 4.
// - Clock out divides crystal rate, full rate default, down to 1 Hz.
// - Watchdog counts from one of four selectable source ticks.
// - Watchdog expiry raises an interrupt.
// - Alarm match raises an interrupt when the alarm interrupt enable is set.
// - Capture trigger copies current time and date into its set.
`timescale 1ns/1ps
`default_nettype none
module rtcm_register_map (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic       clk_en,
	// Byte-level serial transaction port
	input  wire logic       txn_active,
	input  wire logic       ptr_load,
	input  wire logic [5:0] ptr_value,
	input  wire logic       wr_strb,
	input  wire logic [7:0] wr_data,
	input  wire logic       rd_strb,
	output logic      [7:0] rd_data_ff,
	// Time bases and events
	input  wire logic       tick_100hz,
	input  wire logic       osc_tick,
	input  wire logic [3:0] wd_src_tick,
	input  wire logic [3:0] capture_trig,
	// Outputs
	output logic            irq_ff,
	output logic            divided_clock_pin_ff,
	output logic            temp_meas_ff
);
	logic [7:0]  regs_ff [0:rtcm_pkg::NREG-1];
	logic [5:0]  ptr_ff;
	logic        otpr_ff;
	logic [7:0]  pend_ff;
	logic [3:0]  cap_pend_ff;
	logic        sec_step_ff;
	logic [7:0]  wd_cnt_ff;
	logic [15:0] div_cnt_ff;
	logic [5:0]  temp_cnt_ff;
	logic        run;
	logic        tick_go;
	logic [3:0]  cap_do;
	logic        wr_ok;
	logic        sr_cmd;
	logic        af_set;
	logic        wd_expire;
	logic        alarm_match;
	logic [7:0]  rd_val;
	logic [7:0]  flag_base;
	logic [7:0]  capf_base;
	logic [7:0]  n_hund, n_sec, n_min, n_hour, n_day, n_wday, n_mon, n_year;
	logic        c_sec, c_min, c_hour, c_day, c_mon, c_year;

	function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] top,
		input logic [7:0] base);
		if (v == top) begin
			bcd_step = base;
		end else if (v[3:0] == 4'h9) begin
			bcd_step = {v[7:4] + 4'h1, 4'h0};
		end else begin
			bcd_step = {v[7:4], v[3:0] + 4'h1};
		end
	endfunction

	function automatic logic [7:0] month_len(input logic [7:0] mon, input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
			: (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		case (mon)
			8'h02: month_len = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
			default: month_len = 8'h31;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Calendar advance by one hundredth
	always_comb begin
		logic [7:0] t_s, t_m, t_h, h12;
		t_s = bcd_step({1'b0, regs_ff[rtcm_pkg::A_SEC][6:0]}, 8'h59, 8'h00);
		t_m = bcd_step({1'b0, regs_ff[rtcm_pkg::A_MIN][6:0]}, 8'h59, 8'h00);
		h12 = {3'h0, regs_ff[rtcm_pkg::A_HOUR][4:0]};
		t_h = 8'h00;
		n_hund = bcd_step(regs_ff[rtcm_pkg::A_HUND], 8'h99, 8'h00);
		c_sec = regs_ff[rtcm_pkg::A_HUND] == 8'h99;
		n_sec = regs_ff[rtcm_pkg::A_SEC];
		n_min = regs_ff[rtcm_pkg::A_MIN];
		n_hour = regs_ff[rtcm_pkg::A_HOUR];
		n_day = regs_ff[rtcm_pkg::A_DAY];
		n_wday = regs_ff[rtcm_pkg::A_WDAY];
		n_mon = regs_ff[rtcm_pkg::A_MON];
		n_year = regs_ff[rtcm_pkg::A_YEAR];
		c_min = c_sec && regs_ff[rtcm_pkg::A_SEC][6:0] == 7'h59;
		c_hour = c_min && regs_ff[rtcm_pkg::A_MIN][6:0] == 7'h59;
		if (c_sec) begin
			n_sec = {regs_ff[rtcm_pkg::A_SEC][7], t_s[6:0]};
		end
		if (c_min) begin
			n_min = {1'b0, t_m[6:0]};
		end
		if (regs_ff[rtcm_pkg::A_GEN_CTL][rtcm_pkg::B_12_24]) begin
			c_day = c_hour && h12 == 8'h11 && regs_ff[rtcm_pkg::A_HOUR][5];
			t_h = bcd_step(h12, 8'h12, 8'h01);
			if (c_hour) begin
				n_hour = {2'h0, regs_ff[rtcm_pkg::A_HOUR][5] ^ (h12 == 8'h11), t_h[4:0]};
			end
		end else begin
			c_day = c_hour && regs_ff[rtcm_pkg::A_HOUR][5:0] == 6'h23;
			t_h = bcd_step({2'h0, regs_ff[rtcm_pkg::A_HOUR][5:0]}, 8'h23, 8'h00);
			if (c_hour) begin
				n_hour = {2'h0, t_h[5:0]};
			end
		end
		c_mon = c_day && regs_ff[rtcm_pkg::A_DAY] == month_len(regs_ff[rtcm_pkg::A_MON],
			regs_ff[rtcm_pkg::A_YEAR]);
		c_year = c_mon && regs_ff[rtcm_pkg::A_MON] == 8'h12;
		if (c_day) begin
			n_day = c_mon ? 8'h01 : bcd_step(regs_ff[rtcm_pkg::A_DAY], 8'h31, 8'h01);
			n_wday = (regs_ff[rtcm_pkg::A_WDAY][2:0] == 3'h6) ? 8'h00
				: {5'h0, regs_ff[rtcm_pkg::A_WDAY][2:0] + 3'h1};
		end
		if (c_mon) begin
			n_mon = bcd_step(regs_ff[rtcm_pkg::A_MON], 8'h12, 8'h01);
		end
		if (c_year) begin
			n_year = bcd_step(regs_ff[rtcm_pkg::A_YEAR], 8'h99, 8'h00);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Freeze, pending ticks and capture scheduling
	assign run = !txn_active && !regs_ff[rtcm_pkg::A_GEN_CTL][rtcm_pkg::B_STOP];
	assign tick_go = run && (pend_ff != 8'h00 || tick_100hz);
	assign cap_do = (cap_pend_ff | capture_trig) & {4{!txn_active}};

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pend_ff <= 8'h00;
		end else if (clk_en) begin
			pend_ff <= pend_ff
				+ {7'h0, tick_100hz && !regs_ff[rtcm_pkg::A_GEN_CTL][rtcm_pkg::B_STOP]
					&& pend_ff != rtcm_pkg::PEND_MAX}
				- {7'h0, tick_go};
		end
	end
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cap_pend_ff <= 4'h0;
		end else if (clk_en) begin
			cap_pend_ff <= (cap_pend_ff | capture_trig) & ~cap_do;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register storage
	assign wr_ok = wr_strb && ptr_ff <= rtcm_pkg::ADDR_LAST;
	assign sr_cmd = wr_ok && ptr_ff == rtcm_pkg::A_SOFT_RST;

	always_comb begin
		flag_base = regs_ff[rtcm_pkg::A_FLAG_CTL];
		capf_base = regs_ff[rtcm_pkg::A_CAP_FLAGS];
		if (sr_cmd && wr_data[rtcm_pkg::B_SR]) begin
			flag_base = rtcm_pkg::reset_value(rtcm_pkg::A_FLAG_CTL);
			capf_base = rtcm_pkg::reset_value(rtcm_pkg::A_CAP_FLAGS);
		end else if (wr_ok && ptr_ff == rtcm_pkg::A_FLAG_CTL) begin
			flag_base = wr_data & rtcm_pkg::read_mask(rtcm_pkg::A_FLAG_CTL);
		end else if (wr_ok && ptr_ff == rtcm_pkg::A_CAP_FLAGS) begin
			capf_base = wr_data & rtcm_pkg::read_mask(rtcm_pkg::A_CAP_FLAGS);
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < rtcm_pkg::NREG; i++) begin
				regs_ff[i] <= rtcm_pkg::reset_value(6'(i));
			end
		end else if (clk_en) begin
			if (tick_go) begin
				regs_ff[rtcm_pkg::A_HUND] <= n_hund;
				regs_ff[rtcm_pkg::A_SEC] <= n_sec;
				regs_ff[rtcm_pkg::A_MIN] <= n_min;
				regs_ff[rtcm_pkg::A_HOUR] <= n_hour;
				regs_ff[rtcm_pkg::A_DAY] <= n_day;
				regs_ff[rtcm_pkg::A_WDAY] <= n_wday;
				regs_ff[rtcm_pkg::A_MON] <= n_mon;
				regs_ff[rtcm_pkg::A_YEAR] <= n_year;
			end
			for (int c = 0; c < rtcm_pkg::TS_CHANS; c++) begin
				if (cap_do[c]) begin
					for (int k = 1; k < rtcm_pkg::TS_STRIDE; k++) begin
						regs_ff[6'(rtcm_pkg::A_TS_BASE + c * rtcm_pkg::TS_STRIDE + k)] <=
							regs_ff[6'(rtcm_pkg::A_SEC + k - 1 + (k > 4 ? 1 : 0))]
							& rtcm_pkg::read_mask(6'(rtcm_pkg::A_TS_BASE + k));
					end
				end
			end
			if (wr_ok && !sr_cmd) begin
				regs_ff[ptr_ff] <= wr_data & rtcm_pkg::read_mask(ptr_ff);
			end
			if (sr_cmd) begin
				if (wr_data[rtcm_pkg::B_SR]) begin
					for (int i = 0; i < 5; i++) begin
						regs_ff[i] <= rtcm_pkg::reset_value(6'(i));
					end
				end
				if (wr_data[rtcm_pkg::B_CPR]) begin
					regs_ff[rtcm_pkg::A_HUND] <= 8'h00;
				end
				if (wr_data[rtcm_pkg::B_CTS]) begin
					for (int i = rtcm_pkg::A_TS_BASE; i <= rtcm_pkg::A_TS_END; i++) begin
						regs_ff[i] <= 8'h00;
					end
				end
			end
			// Hardware set wins over a clearing write
			regs_ff[rtcm_pkg::A_FLAG_CTL] <= flag_base
				| ({7'h0, wd_expire} << rtcm_pkg::B_WATCHDOG_EXPIRED_FLAG)
				| ({7'h0, af_set} << rtcm_pkg::B_AF);
			regs_ff[rtcm_pkg::A_CAP_FLAGS] <= capf_base | {cap_do, 4'h0};
		end
	end

	// Undefined bit: no reset of any kind touches it
	always_ff @(posedge clock) begin
		if (clk_en && wr_ok && ptr_ff == rtcm_pkg::A_DIVIDED_CLOCK_PIN) begin
			otpr_ff <= wr_data[rtcm_pkg::B_OTPR];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Address pointer and read data
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ptr_ff <= rtcm_pkg::ADDR_FIRST;
		end else if (clk_en) begin
			if (ptr_load) begin
				ptr_ff <= ptr_value;
			end else if (rd_strb || wr_strb) begin
				ptr_ff <= (ptr_ff >= rtcm_pkg::ADDR_LAST) ? rtcm_pkg::ADDR_FIRST
					: ptr_ff + 6'h01;
			end
		end
	end

	always_comb begin
		rd_val = (ptr_ff <= rtcm_pkg::ADDR_LAST) ? regs_ff[ptr_ff] : 8'h00;
		if (ptr_ff == rtcm_pkg::A_DIVIDED_CLOCK_PIN) begin
			rd_val[rtcm_pkg::B_OTPR] = otpr_ff;
		end
		rd_val = rd_val & rtcm_pkg::read_mask(ptr_ff);
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rd_data_ff <= 8'h00;
		end else if (clk_en && rd_strb) begin
			rd_data_ff <= rd_val;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Alarm and interrupt
	always_comb begin
		logic [4:0] hit, en;
		en = ~{regs_ff[rtcm_pkg::A_AL_SEC][rtcm_pkg::B_AE], regs_ff[rtcm_pkg::A_AL_MIN][7],
			regs_ff[rtcm_pkg::A_AL_HOUR][7], regs_ff[rtcm_pkg::A_AL_DAY][7],
			regs_ff[rtcm_pkg::A_AL_WDAY][7]};
		hit = {regs_ff[rtcm_pkg::A_AL_SEC][6:0] == regs_ff[rtcm_pkg::A_SEC][6:0],
			regs_ff[rtcm_pkg::A_AL_MIN][6:0] == regs_ff[rtcm_pkg::A_MIN][6:0],
			regs_ff[rtcm_pkg::A_AL_HOUR][5:0] == regs_ff[rtcm_pkg::A_HOUR][5:0],
			regs_ff[rtcm_pkg::A_AL_DAY][5:0] == regs_ff[rtcm_pkg::A_DAY][5:0],
			regs_ff[rtcm_pkg::A_AL_WDAY][2:0] == regs_ff[rtcm_pkg::A_WDAY][2:0]};
		alarm_match = (en != 5'h00) && ((hit | ~en) == 5'h1F);
	end
	assign af_set = sec_step_ff && alarm_match;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sec_step_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else if (clk_en) begin
			sec_step_ff <= tick_go && c_sec;
			irq_ff <= (regs_ff[rtcm_pkg::A_FLAG_CTL][rtcm_pkg::B_AF]
				&& regs_ff[rtcm_pkg::A_FLAG_CTL][rtcm_pkg::B_AIE])
				|| regs_ff[rtcm_pkg::A_FLAG_CTL][rtcm_pkg::B_WATCHDOG_EXPIRED_FLAG];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Watchdog
	assign wd_expire = regs_ff[rtcm_pkg::A_WD_CTL][rtcm_pkg::B_WD_EN] && wd_cnt_ff == 8'h01
		&& wd_src_tick[regs_ff[rtcm_pkg::A_WD_CTL][1:0]];

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wd_cnt_ff <= 8'h00;
		end else if (clk_en) begin
			if (wr_ok && ptr_ff == rtcm_pkg::A_WD_VAL) begin
				wd_cnt_ff <= wr_data;
			end else if (regs_ff[rtcm_pkg::A_WD_CTL][rtcm_pkg::B_WD_EN] && wd_cnt_ff != 8'h00
				&& wd_src_tick[regs_ff[rtcm_pkg::A_WD_CTL][1:0]]) begin
				wd_cnt_ff <= wd_cnt_ff - 8'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Clock out divider and temperature interval
	always_ff @(posedge clock or posedge sys_rst) begin
		logic [2:0]  cof;
		logic [15:0] half;
		if (sys_rst) begin
			div_cnt_ff <= 16'h0000;
			divided_clock_pin_ff <= 1'b0;
		end else if (clk_en) begin
			cof = regs_ff[rtcm_pkg::A_DIVIDED_CLOCK_PIN][2:0];
			half = (cof == rtcm_pkg::COF_1HZ) ? 16'h0001 << rtcm_pkg::SHIFT_1HZ
				: 16'h0001 << cof;
			if (cof == rtcm_pkg::COF_OFF) begin
				div_cnt_ff <= 16'h0000;
				divided_clock_pin_ff <= 1'b0;
			end else if (osc_tick) begin
				if (div_cnt_ff >= half - 16'h0001) begin
					div_cnt_ff <= 16'h0000;
					divided_clock_pin_ff <= !divided_clock_pin_ff;
				end else begin
					div_cnt_ff <= div_cnt_ff + 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		logic [5:0] interval;
		if (sys_rst) begin
			temp_cnt_ff <= 6'h00;
			temp_meas_ff <= 1'b0;
		end else if (clk_en) begin
			interval = rtcm_pkg::TEMP_MAX_MIN >> regs_ff[rtcm_pkg::A_DIVIDED_CLOCK_PIN][7:6];
			temp_meas_ff <= 1'b0;
			if (tick_go && c_min) begin
				if (temp_cnt_ff >= interval - 6'h01) begin
					temp_cnt_ff <= 6'h00;
					temp_meas_ff <= 1'b1;
				end else begin
					temp_cnt_ff <= temp_cnt_ff + 6'h01;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	AST_PTR_STEP: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && (rd_strb || wr_strb) && !ptr_load && ptr_ff < rtcm_pkg::ADDR_LAST
		|=> ptr_ff == $past(ptr_ff) + 6'h01)
		else $error("pointer did not step after a data byte");
	AST_PTR_WRAP: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && rd_strb && !ptr_load && ptr_ff == rtcm_pkg::ADDR_LAST |=> ptr_ff == 6'h00)
		else $error("pointer did not wrap to the first register");
	AST_DAY_ROLL: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && tick_go && c_mon && !wr_strb |=> regs_ff[rtcm_pkg::A_DAY] == 8'h01)
		else $error("day did not roll to one at month end");
	AST_FREEZE: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && txn_active && !wr_strb
		|=> regs_ff[rtcm_pkg::A_HUND] == $past(regs_ff[rtcm_pkg::A_HUND]))
		else $error("time counter moved during a transaction");
	AST_CAP_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && txn_active && capture_trig[0] |=> cap_pend_ff[0])
		else $error("capture during a transaction was not held");
	AST_UNUSED_ZERO: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && rd_strb && ptr_ff == rtcm_pkg::A_FLAG_CTL |=> rd_data_ff[5] == 1'b0
		&& rd_data_ff[3:2] == 2'h0 && rd_data_ff[0] == 1'b0)
		else $error("unused bit read as one");
	AST_ALARM_IRQ: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && af_set ##1 clk_en && regs_ff[rtcm_pkg::A_FLAG_CTL][rtcm_pkg::B_AIE]
		|=> irq_ff)
		else $error("enabled alarm match raised no interrupt");
	AST_WD_IRQ: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && wd_expire ##1 clk_en |-> regs_ff[rtcm_pkg::A_FLAG_CTL][rtcm_pkg::B_WATCHDOG_EXPIRED_FLAG]
		##1 irq_ff)
		else $error("watchdog expiry raised no interrupt");
	AST_PEND_KEEP: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && txn_active && tick_100hz && pend_ff != rtcm_pkg::PEND_MAX
		&& !regs_ff[rtcm_pkg::A_GEN_CTL][rtcm_pkg::B_STOP] |=> pend_ff == $past(pend_ff) + 8'h01)
		else $error("tick during a transaction was lost");
endmodule
`default_nettype wire

// [rtcm_host.sv]
// Host model driving the byte transaction port of the register bank
`timescale 1ns/1ps
`default_nettype none
module rtcm_host (
	// Clock
	input  wire logic       clock,
	// Transaction port
	output logic            txn_active,
	output logic            ptr_load,
	output logic      [5:0] ptr_value,
	output logic            wr_strb,
	output logic      [7:0] wr_data,
	output logic            rd_strb,
	input  wire logic [7:0] rd_data_ff
);
	initial begin
		txn_active = 1'b0;
		ptr_load = 1'b0;
		ptr_value = 6'h2A;
		wr_strb = 1'b0;
		wr_data = 8'h5A;
		rd_strb = 1'b0;
	end
	// Released lines show the inverse so stale values cannot pass
	task automatic open_at(input logic [5:0] a);
		@(posedge clock);
		txn_active <= 1'b1;
		ptr_load <= 1'b1;
		ptr_value <= a;
		@(posedge clock);
		ptr_load <= 1'b0;
		ptr_value <= ~a;
	endtask
	task automatic put(input logic [7:0] v);
		@(posedge clock);
		wr_strb <= 1'b1;
		wr_data <= v;
		@(posedge clock);
		wr_strb <= 1'b0;
		wr_data <= ~v;
	endtask
	task automatic get(output logic [7:0] v);
		@(posedge clock);
		rd_strb <= 1'b1;
		@(posedge clock);
		rd_strb <= 1'b0;
		@(negedge clock);
		v = rd_data_ff;
	endtask
	task automatic close();
		@(posedge clock);
		txn_active <= 1'b0;
	endtask
endmodule
`default_nettype wire

// [rtcm_register_map_tb.sv]
// Self-checking bench for the register bank
`timescale 1ns/1ps
`default_nettype none
module rtcm_register_map_tb;
	logic        clock;
	logic        sys_rst;
	logic        tick_100hz;
	logic        osc_tick;
	logic [3:0]  wd_src_tick;
	logic [3:0]  capture_trig;
	logic        txn_active;
	logic        ptr_load;
	logic [5:0]  ptr_value;
	logic        wr_strb;
	logic [7:0]  wr_data;
	logic        rd_strb;
	logic [7:0]  rd_data_ff;
	logic        irq_ff;
	logic        clk_en;
	logic        divided_clock_pin_ff;
	logic        temp_meas_ff;
	logic        osc_q;
	logic [31:0] rng;
	logic [31:0] bg_rng;
	logic [7:0]  d;
	logic [7:0]  v [4];
	logic [7:0]  rst_tab [19] = '{8'h08, 8'h00, 8'hE0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80,
		8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h01, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80};
	logic [7:0]  cal [3][5] = '{'{8'h01, 8'h28, 8'h02, 8'h01, 8'h03},
		'{8'h04, 8'h28, 8'h02, 8'h29, 8'h02}, '{8'h01, 8'h30, 8'h04, 8'h01, 8'h05}};
	logic [7:0]  cap [6] = '{8'h34, 8'h12, 8'h07, 8'h09, 8'h10, 8'h23};
	int          n_mismatch = 0;
	int          num_checks = 0;
	int          cyc = 0;
	int          n_temp = 0;
	int          n_temp0;

	rtcm_register_map dut (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
		.txn_active(txn_active), .ptr_load(ptr_load), .ptr_value(ptr_value),
		.wr_strb(wr_strb), .wr_data(wr_data), .rd_strb(rd_strb), .rd_data_ff(rd_data_ff),
		.tick_100hz(tick_100hz), .osc_tick(osc_tick), .wd_src_tick(wd_src_tick),
		.capture_trig(capture_trig), .irq_ff(irq_ff),
		.divided_clock_pin_ff(divided_clock_pin_ff), .temp_meas_ff(temp_meas_ff));
	rtcm_host host (.clock(clock), .txn_active(txn_active), .ptr_load(ptr_load),
		.ptr_value(ptr_value), .wr_strb(wr_strb), .wr_data(wr_data), .rd_strb(rd_strb),
		.rd_data_ff(rd_data_ff));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		xs = x ^ (x << 5);
	endfunction
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic rd(input logic [5:0] a, output logic [7:0] r);
		host.open_at(a);
		host.get(r);
		host.close();
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] w);
		host.open_at(a);
		host.put(w);
		host.close();
	endtask
	task automatic tick();
		@(posedge clock);
		tick_100hz <= 1'b1;
		@(posedge clock);
		tick_100hz <= 1'b0;
		repeat (4) @(posedge clock);
	endtask
	task automatic set_time(input logic [7:0] h, s, m, hr, dy, mo, yr);
		host.open_at(6'h06);
		host.put(h);
		host.put(s);
		host.put(m);
		host.put(hr);
		host.put(dy);
		host.put(8'h03);
		host.put(mo);
		host.put(yr);
		host.close();
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// Free-running random time bases
	always @(posedge clock) begin
		bg_rng <= xs(bg_rng);
		osc_tick <= bg_rng[0];
		osc_q <= osc_tick;
		if (temp_meas_ff)
			n_temp <= n_temp + 1;
		wd_src_tick <= bg_rng[4:1];
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_mismatch++;
			end_sim();
		end
	end
	initial begin
		sys_rst = 1'b1;
		clk_en = 1'b1;
		tick_100hz = 1'b0;
		capture_trig = 4'h0;
		osc_tick = 1'b0;
		wd_src_tick = 4'h0;
		rng = 32'h8D2B5C2C;
		bg_rng = 32'h8D2B5C2C;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		host.open_at(6'h00);
		for (int i = 0; i < 19; i++) begin
			host.get(d);
			check("reset value", d, rst_tab[i]);
		end
		host.close();
		host.open_at(6'h36);
		host.get(d);
		host.get(d);
		host.close();
		check("wrap to first", d, 8'h08);
		wr(6'h37, 8'hFF);
		rd(6'h37, d);
		check("unmapped", d, 8'h00);
		$display("test reset_map done");
		for (int k = 0; k < 4; k++) begin
			host.open_at(6'h0E);
			for (int i = 0; i < 4; i++) begin
				rng = xs(rng);
				v[i] = rng[7:0];
				host.put(v[i]);
			end
			host.open_at(6'h0E);
			for (int i = 0; i < 4; i++) begin
				host.get(d);
				check("alarm readback", d, v[i] & ((i < 2) ? 8'hFF : 8'hBF));
			end
			host.close();
		end
		$display("test random_rw done");
		for (int i = 0; i < 3; i++) begin
			set_time(8'h99, 8'h59, 8'h59, 8'h23, cal[i][1], cal[i][2], cal[i][0]);
			tick();
			rd(6'h0A, d);
			check("day", d, cal[i][3]);
			rd(6'h0C, d);
			check("month", d, cal[i][4]);
			rd(6'h09, d);
			check("hour", d, 8'h00);
		end
		$display("test calendar done");
		set_time(8'h98, 8'h10, 8'h00, 8'h10, 8'h15, 8'h06, 8'h20);
		host.open_at(6'h06);
		repeat (3) tick();
		host.get(d);
		host.close();
		check("frozen hundredths", d, 8'h98);
		repeat (8) @(posedge clock);
		rd(6'h06, d);
		check("pending hundredths", d, 8'h01);
		rd(6'h07, d);
		check("carried seconds", d, 8'h11);
		clk_en <= 1'b0;
		tick();
		clk_en <= 1'b1;
		rd(6'h06, d);
		check("enable low holds", d, 8'h01);
		$display("test freeze done");
		wr(6'h00, 8'h0C);
		set_time(8'h99, 8'h59, 8'h59, 8'h11, 8'h15, 8'h06, 8'h20);
		tick();
		rd(6'h09, d);
		check("noon in half-day mode", d, 8'h32);
		wr(6'h00, 8'h08);
		$display("test half_day done");
		host.open_at(6'h0E);
		host.put(8'h00);
		for (int i = 0; i < 4; i++)
			host.put(8'h80);
		host.close();
		wr(6'h01, 8'h00);
		set_time(8'h99, 8'h59, 8'h10, 8'h05, 8'h15, 8'h06, 8'h20);
		tick();
		check("irq masked", {7'h00, irq_ff}, 8'h00);
		rd(6'h01, d);
		check("alarm flag", d & 8'h52, 8'h10);
		wr(6'h01, 8'h12);
		repeat (3) @(posedge clock);
		check("irq enabled", {7'h00, irq_ff}, 8'h01);
		wr(6'h01, 8'h02);
		repeat (3) @(posedge clock);
		check("irq cleared", {7'h00, irq_ff}, 8'h00);
		set_time(8'h99, 8'h59, 8'h20, 8'h05, 8'h15, 8'h06, 8'h20);
		tick();
		check("irq on match", {7'h00, irq_ff}, 8'h01);
		wr(6'h0E, 8'h80);
		wr(6'h01, 8'h00);
		$display("test alarm done");
		set_time(8'h25, 8'h34, 8'h12, 8'h07, 8'h09, 8'h10, 8'h23);
		host.open_at(6'h03);
		@(posedge clock);
		rng = xs(rng);
		capture_trig <= rng[3:0] | 4'h1;
		@(posedge clock);
		capture_trig <= 4'h0;
		host.get(d);
		host.close();
		check("capture deferred", d, 8'h00);
		repeat (4) @(posedge clock);
		rd(6'h03, d);
		check("capture flags", d, {rng[3:0] | 4'h1, 4'h0});
		host.open_at(6'h15);
		for (int i = 0; i < 6; i++) begin
			host.get(d);
			check("captured time", d, cap[i]);
		end
		host.close();
		wr(6'h03, 8'h00);
		$display("test capture done");
		@(negedge clock);
		for (int i = 0; i < 16; i++) begin
			d[0] = divided_clock_pin_ff;
			@(negedge clock);
			check("clock out", {7'h00, divided_clock_pin_ff}, {7'h00, d[0] ^ osc_q});
		end
		wr(6'h13, 8'hE7);
		@(negedge clock);
		check("clock out off", {7'h00, divided_clock_pin_ff}, 8'h00);
		n_temp0 = n_temp;
		for (int i = 0; i < 8; i++) begin
			set_time(8'h99, 8'h59, 8'h00, 8'h10, 8'h15, 8'h06, 8'h20);
			tick();
		end
		check("temperature pulses", 8'(n_temp - n_temp0), 8'h02);
		$display("test clock_temp done");
		@(posedge clock);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		rd(6'h13, d);
		check("undefined bit kept", d, 8'h20);
		$display("test reset done");
		host.open_at(6'h35);
		host.put(8'h80);
		host.put(8'h03);
		host.close();
		for (int i = 0; i < 500 && irq_ff !== 1'b1; i++)
			@(posedge clock);
		check("watchdog irq", {7'h00, irq_ff}, 8'h01);
		rd(6'h01, d);
		check("watchdog flag", d & 8'h40, 8'h40);
		$display("test watchdog done");
		end_sim();
	end
endmodule
`default_nettype wire
